// ### uplink_pkg.sv
`default_nettype none

package uplink_pkg;

  // ------------------------------------------------------------
  // clock and line rates
  // ------------------------------------------------------------
  localparam int unsigned CLK_HZ     = 40_000_000;
  localparam int unsigned BAUD_MODEM = 300;
  localparam int unsigned BAUD_SLOW  = 9600;
  localparam int unsigned BAUD_FAST  = 19200;

  // ------------------------------------------------------------
  // bit periods in clock cycles, rounded to nearest
  // ------------------------------------------------------------
  localparam int DIV_W = 18;
  localparam logic [DIV_W-1:0] DIV_MODEM =
    DIV_W'((CLK_HZ + BAUD_MODEM / 2) / BAUD_MODEM);
  localparam logic [DIV_W-1:0] DIV_SLOW =
    DIV_W'((CLK_HZ + BAUD_SLOW / 2) / BAUD_SLOW);
  localparam logic [DIV_W-1:0] DIV_FAST =
    DIV_W'((CLK_HZ + BAUD_FAST / 2) / BAUD_FAST);

  // ------------------------------------------------------------
  // character framing and buffering
  // ------------------------------------------------------------
  localparam int DATA_BITS  = 8;
  localparam int FRAME_BITS = 10;
  localparam int ROUTE_BIT  = 7;
  localparam int FIFO_W     = 8;
  localparam int FIFO_DEPTH = 32;
  localparam int CNT_W      = 6;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic LINE_IDLE = 1'b1;

  // ------------------------------------------------------------
  // state encodings
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    RX_IDLE  = 4'h1,
    RX_START = 4'h2,
    RX_DATA  = 4'h4,
    RX_STOP  = 4'h8
  } rx_state_t;

  typedef enum logic [2:0] {
    W_SCAN  = 3'h1,
    W_COUNT = 3'h2,
    W_PAY   = 3'h4
  } wet_state_t;

  typedef enum logic [2:0] {
    D_SCAN  = 3'h1,
    D_COUNT = 3'h2,
    D_PAY   = 3'h4
  } deck_state_t;

endpackage

`default_nettype wire

// ### uart_link.sv
`timescale 1ns/1ps
`default_nettype none

module uart_link
(
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst,
  // bit period in cycles
  input  wire logic [uplink_pkg::DIV_W-1:0]  div,
  // receive side, rxd already synchronised
  input  wire logic                          rxd,
  output logic      [7:0]                    rx_data,
  output logic                               rx_valid,
  // transmit side
  input  wire logic [7:0]                    tx_data,
  input  wire logic                          tx_start,
  output logic                               tx_busy,
  output logic                               txd
);

  typedef struct packed {
    uplink_pkg::rx_state_t         rst_q;
    logic [uplink_pkg::DIV_W-1:0]  rcnt;
    logic [2:0]                    rbit;
    logic [7:0]                    rsh;
    logic [7:0]                    rdat;
    logic                          rvld;
    logic [uplink_pkg::DIV_W-1:0]  tcnt;
    logic [3:0]                    tbit;
    logic [9:0]                    tsh;
    logic                          busy;
    logic                          txd;
  } uart_t;

  uart_t s;
  uart_t next_s;

  localparam logic [uplink_pkg::DIV_W-1:0] ONE = 18'h00001;

  // ------------------------------------------------------------
  // receiver and transmitter, 1 start, 8 data, 1 stop, no parity
  // ------------------------------------------------------------
  always_comb
  begin
    next_s      = s;
    next_s.rvld = 1'b0;
    case (s.rst_q)
      uplink_pkg::RX_IDLE:
      begin
        if (!rxd)
        begin
          next_s.rst_q = uplink_pkg::RX_START;
          next_s.rcnt  = div >> 1;
        end
      end
      uplink_pkg::RX_START:
      begin
        if (s.rcnt == '0)
        begin
          next_s.rst_q = rxd ? uplink_pkg::RX_IDLE : uplink_pkg::RX_DATA;
          next_s.rcnt  = div - ONE;
          next_s.rbit  = 3'h0;
        end
        else
          next_s.rcnt = s.rcnt - ONE;
      end
      uplink_pkg::RX_DATA:
      begin
        if (s.rcnt == '0)
        begin
          next_s.rsh  = {rxd, s.rsh[7:1]};
          next_s.rcnt = div - ONE;
          next_s.rbit = s.rbit + 3'h1;
          if (s.rbit == 3'h7)
            next_s.rst_q = uplink_pkg::RX_STOP;
        end
        else
          next_s.rcnt = s.rcnt - ONE;
      end
      uplink_pkg::RX_STOP:
      begin
        if (s.rcnt == '0)
        begin
          next_s.rst_q = uplink_pkg::RX_IDLE;
          if (rxd)
          begin
            next_s.rdat = s.rsh;
            next_s.rvld = 1'b1;
          end
        end
        else
          next_s.rcnt = s.rcnt - ONE;
      end
      default:
        next_s.rst_q = uplink_pkg::RX_IDLE;
    endcase
    if (!s.busy)
    begin
      if (tx_start)
      begin
        next_s.tsh  = {1'b1, tx_data, 1'b0};
        next_s.busy = 1'b1;
        next_s.tcnt = div - ONE;
        next_s.tbit = 4'h0;
        next_s.txd  = 1'b0;
      end
    end
    else if (s.tcnt != '0)
      next_s.tcnt = s.tcnt - ONE;
    else if (s.tbit == 4'(uplink_pkg::FRAME_BITS - 1))
    begin
      next_s.busy = 1'b0;
      next_s.txd  = uplink_pkg::LINE_IDLE;
    end
    else
    begin
      next_s.tsh  = {1'b1, s.tsh[9:1]};
      next_s.txd  = s.tsh[1];
      next_s.tbit = s.tbit + 4'h1;
      next_s.tcnt = div - ONE;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s       <= '0;
      s.rst_q <= uplink_pkg::RX_IDLE;
      s.txd   <= uplink_pkg::LINE_IDLE;
    end
    else
      s <= next_s;
  end

  assign rx_data  = s.rdat;
  assign rx_valid = s.rvld;
  assign tx_busy  = s.busy;
  assign txd      = s.txd;

endmodule

`default_nettype wire

// ### byte_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module byte_fifo
#(
  parameter int W     = 8,
  parameter int DEPTH = 32
)
(
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst,
  // filling side
  input  wire logic [W-1:0]               in_data,
  input  wire logic                       in_valid,
  output logic                            in_ready,
  // draining side
  output logic      [W-1:0]               out_data,
  output logic                            out_valid,
  input  wire logic                       out_ready,
  // fill level
  output logic      [$clog2(DEPTH):0]     count
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
    logic                    rdy;
  } fifo_t;

  fifo_t s;
  fifo_t next_s;
  logic  push;
  logic  pop;

  // ------------------------------------------------------------
  // pointers and storage
  // ------------------------------------------------------------
  always_comb
  begin
    next_s = s;
    push   = in_valid && s.rdy;
    pop    = out_ready && (s.cnt != '0);
    for (int i = 0; i < DEPTH; i++)
    begin
      if (push && (s.wp == AW'(i)))
        next_s.mem[i] = in_data;
    end
    if (push)
      next_s.wp = s.wp + AW'(1);
    if (pop)
      next_s.rp = s.rp + AW'(1);
    next_s.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
    next_s.rdy = next_s.cnt != (AW+1)'(DEPTH);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s     <= '0;
      s.rdy <= 1'b1;
    end
    else
      s <= next_s;
  end

  assign in_ready  = s.rdy;
  assign out_data  = s.mem[s.rp];
  assign out_valid = s.cnt != '0;
  assign count     = s.cnt;

endmodule

`default_nettype wire

// ### serial_uplink_mux_router.sv
// Summary of operation
// - instrument line runs at 9600 or 19200 baud, chosen by a strap
// - uplink only carries instrument data upward; downward goes by modem
// - modem characters use 1 start, 8 data, no parity, 1 stop bit
// - underwater: modem byte with bit 7 set goes to water sampler
// - deck: modem byte with bit 7 set is a sampler bottle response
// - underwater: modem byte with bit 7 clear resent to instrument
// - scans go at double rate, leaving a gap for the serial stream
// - instrument bytes buffered during scan, sent as one packet after
// - each packet starts with a count byte of payload bytes following
// - deck splits stream, passes scan, sends payload out at 19200 baud
// - both ends must use the same multiplexed mode
// - recorder output is off while deck demultiplexing is enabled
`timescale 1ns/1ps
`default_nettype none

module serial_uplink_mux_router
#(
  parameter logic [uplink_pkg::DIV_W-1:0] MODEM_BIT_CYC = uplink_pkg::DIV_MODEM,
  parameter logic [uplink_pkg::DIV_W-1:0] SLOW_BIT_CYC  = uplink_pkg::DIV_SLOW
)
(
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RST,
  // underwater: instrument serial line
  input  wire logic        INST_RXD,
  output logic             INST_TXD,
  input  wire logic        INST_BAUD_FAST,
  output logic             INST_OVERRUN,
  // underwater: scan bytes from acquisition logic
  input  wire logic [7:0]  SCAN_DATA,
  input  wire logic        SCAN_VALID,
  input  wire logic        SCAN_LAST,
  output logic             SCAN_READY,
  // underwater: double-rate telemetry out
  output logic      [7:0]  TLM_DATA,
  output logic             TLM_VALID,
  input  wire logic        TLM_READY,
  // underwater: modem and sampler
  input  wire logic        WET_MODEM_RXD,
  output logic      [7:0]  SAMPLER_CMD_DATA,
  output logic             SAMPLER_CMD_VALID,
  // deck: telemetry in
  input  wire logic        DEMUX_EN,
  input  wire logic [7:0]  LINK_DATA,
  input  wire logic        LINK_VALID,
  input  wire logic        LINK_SCAN_END,
  output logic             LINK_READY,
  // deck: scan and recorder out
  output logic      [7:0]  DECK_SCAN_DATA,
  output logic             DECK_SCAN_VALID,
  output logic      [7:0]  REC_DATA,
  output logic             REC_VALID,
  // deck: serial uplink out
  output logic             UPLINK_TXD,
  // deck: modem, host and sampler
  input  wire logic        DECK_MODEM_RXD,
  output logic             DECK_MODEM_TXD,
  input  wire logic [7:0]  HOST_CMD_DATA,
  input  wire logic        HOST_CMD_VALID,
  output logic             HOST_CMD_READY,
  output logic      [7:0]  SAMPLER_RESP_DATA,
  output logic             SAMPLER_RESP_VALID
);

  typedef struct packed {
    logic [1:0]                inst_rxd_sy;
    logic [1:0]                wmod_rxd_sy;
    logic [1:0]                dmod_rxd_sy;
    logic [1:0]                baud_sy;
    logic [1:0]                demux_sy;
    uplink_pkg::wet_state_t    wstate;
    logic [7:0]                tlm_data;
    logic                      tlm_valid;
    logic                      scan_ready;
    logic [7:0]                wremain;
    logic                      overrun;
    logic [7:0]                icmd;
    logic                      icmd_valid;
    logic [7:0]                scmd;
    logic                      scmd_valid;
    uplink_pkg::deck_state_t   dstate;
    logic [7:0]                dremain;
    logic [7:0]                dscan;
    logic                      dscan_valid;
    logic [7:0]                rec;
    logic                      rec_valid;
    logic                      host_ready;
    logic [7:0]                sresp;
    logic                      sresp_valid;
  } top_t;

  top_t s;
  top_t next_s;

  // ------------------------------------------------------------
  // internal wires
  // ------------------------------------------------------------
  logic [uplink_pkg::DIV_W-1:0]  inst_div;
  logic [7:0]                    inst_rx_data;
  logic                          inst_rx_valid;
  logic                          inst_busy;
  logic                          inst_start;
  logic                          wf_in_ready;
  logic [7:0]                    wf_data;
  logic                          wf_valid;
  logic                          wf_pop;
  logic [uplink_pkg::CNT_W-1:0]  wf_count;
  logic [7:0]                    wmod_data;
  logic                          wmod_valid;
  logic                          df_push;
  logic [7:0]                    df_data;
  logic                          df_valid;
  logic                          df_pop;
  logic                          up_busy;
  logic [7:0]                    dmod_data;
  logic                          dmod_valid;
  logic                          dmod_busy;
  logic                          host_take;
  logic                          link_take;
  logic                          tlm_free;

  // ------------------------------------------------------------
  // underwater: instrument line at strapped rate
  // ------------------------------------------------------------
  assign inst_div = s.baud_sy[1] ? uplink_pkg::DIV_FAST
                                 : SLOW_BIT_CYC;

  uart_link u_inst
  (
    .clk      (CLK),
    .rst      (RST),
    .div      (inst_div),
    .rxd      (s.inst_rxd_sy[1]),
    .rx_data  (inst_rx_data),
    .rx_valid (inst_rx_valid),
    .tx_data  (s.icmd),
    .tx_start (inst_start),
    .tx_busy  (inst_busy),
    .txd      (INST_TXD)
  );

  byte_fifo
  #(
    .W     (uplink_pkg::FIFO_W),
    .DEPTH (uplink_pkg::FIFO_DEPTH)
  )
  u_wet_fifo
  (
    .clk       (CLK),
    .rst       (RST),
    .in_data   (inst_rx_data),
    .in_valid  (inst_rx_valid),
    .in_ready  (wf_in_ready),
    .out_data  (wf_data),
    .out_valid (wf_valid),
    .out_ready (wf_pop),
    .count     (wf_count)
  );

  // ------------------------------------------------------------
  // modem receivers and deck transmitters
  // ------------------------------------------------------------
  uart_link u_wet_modem
  (
    .clk      (CLK),
    .rst      (RST),
    .div      (MODEM_BIT_CYC),
    .rxd      (s.wmod_rxd_sy[1]),
    .rx_data  (wmod_data),
    .rx_valid (wmod_valid),
    .tx_data  (8'h00),
    .tx_start (1'b0),
    .tx_busy  (),
    .txd      ()
  );

  uart_link u_deck_modem
  (
    .clk      (CLK),
    .rst      (RST),
    .div      (MODEM_BIT_CYC),
    .rxd      (s.dmod_rxd_sy[1]),
    .rx_data  (dmod_data),
    .rx_valid (dmod_valid),
    .tx_data  (HOST_CMD_DATA),
    .tx_start (host_take),
    .tx_busy  (dmod_busy),
    .txd      (DECK_MODEM_TXD)
  );

  byte_fifo
  #(
    .W     (uplink_pkg::FIFO_W),
    .DEPTH (uplink_pkg::FIFO_DEPTH)
  )
  u_deck_fifo
  (
    .clk       (CLK),
    .rst       (RST),
    .in_data   (LINK_DATA),
    .in_valid  (df_push),
    .in_ready  (LINK_READY),
    .out_data  (df_data),
    .out_valid (df_valid),
    .out_ready (df_pop),
    .count     ()
  );

  uart_link u_uplink
  (
    .clk      (CLK),
    .rst      (RST),
    .div      (uplink_pkg::DIV_FAST),
    .rxd      (uplink_pkg::LINE_IDLE),
    .rx_data  (),
    .rx_valid (),
    .tx_data  (df_data),
    .tx_start (df_pop),
    .tx_busy  (up_busy),
    .txd      (UPLINK_TXD)
  );

  // ------------------------------------------------------------
  // handshake terms
  // ------------------------------------------------------------
  assign inst_start = s.icmd_valid && !inst_busy;
  assign host_take  = HOST_CMD_VALID && s.host_ready;
  assign link_take  = LINK_VALID && LINK_READY;
  assign df_pop     = df_valid && !up_busy;
  assign tlm_free   = !s.tlm_valid || TLM_READY;
  assign wf_pop     = (s.wstate == uplink_pkg::W_PAY) && tlm_free;
  assign df_push    = link_take && (s.dstate == uplink_pkg::D_PAY);

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb
  begin
    next_s = s;
    next_s.inst_rxd_sy = {s.inst_rxd_sy[0], INST_RXD};
    next_s.wmod_rxd_sy = {s.wmod_rxd_sy[0], WET_MODEM_RXD};
    next_s.dmod_rxd_sy = {s.dmod_rxd_sy[0], DECK_MODEM_RXD};
    next_s.baud_sy     = {s.baud_sy[0], INST_BAUD_FAST};
    next_s.demux_sy    = {s.demux_sy[0], DEMUX_EN};
    next_s.scmd_valid  = 1'b0;
    next_s.dscan_valid = 1'b0;
    next_s.rec_valid   = 1'b0;
    next_s.sresp_valid = 1'b0;

    // underwater: bytes lost to a full buffer raise a sticky flag
    if (inst_rx_valid && !wf_in_ready)
      next_s.overrun = 1'b1;

    // underwater telemetry: scan first, then packet in the gap
    if (TLM_READY)
      next_s.tlm_valid = 1'b0;
    case (s.wstate)
      uplink_pkg::W_SCAN:
      begin
        if (SCAN_VALID && s.scan_ready)
        begin
          next_s.tlm_data  = SCAN_DATA;
          next_s.tlm_valid = 1'b1;
          if (SCAN_LAST)
            next_s.wstate = uplink_pkg::W_COUNT;
        end
      end
      uplink_pkg::W_COUNT:
      begin
        if (tlm_free)
        begin
          next_s.tlm_data  = {2'h0, wf_count};
          next_s.tlm_valid = 1'b1;
          next_s.wremain   = {2'h0, wf_count};
          next_s.wstate    = (wf_count == '0) ? uplink_pkg::W_SCAN
                                              : uplink_pkg::W_PAY;
        end
      end
      uplink_pkg::W_PAY:
      begin
        if (tlm_free)
        begin
          next_s.tlm_data  = wf_data;
          next_s.tlm_valid = 1'b1;
          next_s.wremain   = s.wremain - 8'h01;
          if (s.wremain == 8'h01)
            next_s.wstate = uplink_pkg::W_SCAN;
        end
      end
      default:
        next_s.wstate = uplink_pkg::W_SCAN;
    endcase
    next_s.scan_ready = (next_s.wstate == uplink_pkg::W_SCAN)
                        && !next_s.tlm_valid;

    // underwater modem: route by the top data bit
    if (inst_start)
      next_s.icmd_valid = 1'b0;
    if (wmod_valid)
    begin
      if (wmod_data[uplink_pkg::ROUTE_BIT])
      begin
        next_s.scmd       = wmod_data;
        next_s.scmd_valid = 1'b1;
      end
      else
      begin
        next_s.icmd       = wmod_data;
        next_s.icmd_valid = 1'b1;
      end
    end

    // deck: split scan bytes from packets
    if (link_take)
    begin
      case (s.dstate)
        uplink_pkg::D_SCAN:
        begin
          next_s.dscan       = LINK_DATA;
          next_s.dscan_valid = 1'b1;
          next_s.rec         = LINK_DATA;
          next_s.rec_valid   = !s.demux_sy[1];
          if (LINK_SCAN_END && s.demux_sy[1])
            next_s.dstate = uplink_pkg::D_COUNT;
        end
        uplink_pkg::D_COUNT:
        begin
          next_s.dremain = LINK_DATA;
          next_s.dstate  = (LINK_DATA == 8'h00)
                           ? uplink_pkg::D_SCAN
                           : uplink_pkg::D_PAY;
        end
        uplink_pkg::D_PAY:
        begin
          next_s.dremain = s.dremain - 8'h01;
          if (s.dremain == 8'h01)
            next_s.dstate = uplink_pkg::D_SCAN;
        end
        default:
          next_s.dstate = uplink_pkg::D_SCAN;
      endcase
    end

    // deck modem: sampler responses, host commands downward
    if (dmod_valid && dmod_data[uplink_pkg::ROUTE_BIT])
    begin
      next_s.sresp       = dmod_data;
      next_s.sresp_valid = 1'b1;
    end
    next_s.host_ready = !dmod_busy && !host_take;
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      s             <= '0;
      s.inst_rxd_sy <= 2'h3;
      s.wmod_rxd_sy <= 2'h3;
      s.dmod_rxd_sy <= 2'h3;
      s.wstate      <= uplink_pkg::W_SCAN;
      s.dstate      <= uplink_pkg::D_SCAN;
    end
    else
      s <= next_s;
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign INST_OVERRUN       = s.overrun;
  assign SCAN_READY         = s.scan_ready;
  assign TLM_DATA           = s.tlm_data;
  assign TLM_VALID          = s.tlm_valid;
  assign SAMPLER_CMD_DATA   = s.scmd;
  assign SAMPLER_CMD_VALID  = s.scmd_valid;
  assign DECK_SCAN_DATA     = s.dscan;
  assign DECK_SCAN_VALID    = s.dscan_valid;
  assign REC_DATA           = s.rec;
  assign REC_VALID          = s.rec_valid;
  assign HOST_CMD_READY     = s.host_ready;
  assign SAMPLER_RESP_DATA  = s.sresp;
  assign SAMPLER_RESP_VALID = s.sresp_valid;

endmodule

`default_nettype wire

// ### uplink_props.sv
`timescale 1ns/1ps
`default_nettype none

module uplink_props
(
  // ------------------------------------------------------------
  // watched ports
  // ------------------------------------------------------------
  input wire logic       CLK, RST, SCAN_VALID, SCAN_READY, TLM_VALID,
  input wire logic       TLM_READY, SAMPLER_CMD_VALID, DEMUX_EN, LINK_VALID,
  input wire logic       LINK_READY, DECK_SCAN_VALID, REC_VALID,
  input wire logic       HOST_CMD_VALID, HOST_CMD_READY, SAMPLER_RESP_VALID,
  input wire logic [7:0] SCAN_DATA, TLM_DATA, SAMPLER_CMD_DATA, LINK_DATA,
  input wire logic [7:0] DECK_SCAN_DATA, SAMPLER_RESP_DATA
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);

  rec_off_a: assert property ($past(DEMUX_EN,2) && $past(DEMUX_EN,3)
    |-> !REC_VALID) else $error("recorder active in demux");
  cmd_route_a: assert property (SAMPLER_CMD_VALID
    |-> SAMPLER_CMD_DATA[7]) else $error("sampler cmd without bit 7");
  cmd_pulse_a: assert property (SAMPLER_CMD_VALID
    |=> !SAMPLER_CMD_VALID) else $error("sampler cmd not a pulse");
  resp_route_a: assert property (SAMPLER_RESP_VALID
    |-> SAMPLER_RESP_DATA[7]) else $error("response without bit 7");
  tlm_hold_a: assert property (TLM_VALID && !TLM_READY
    |=> TLM_VALID && $stable(TLM_DATA)) else $error("telemetry dropped");
  scan_pass_a: assert property (SCAN_VALID && SCAN_READY
    |=> TLM_VALID && TLM_DATA == $past(SCAN_DATA)) else $error("scan lost");
  scan_block_a: assert property (TLM_VALID
    |-> !SCAN_READY) else $error("scan taken while busy");
  deck_scan_a: assert property (LINK_VALID && LINK_READY && !DEMUX_EN
    && !$past(DEMUX_EN,2) |=> DECK_SCAN_VALID && REC_VALID
    && DECK_SCAN_DATA == $past(LINK_DATA)) else $error("deck scan lost");
  host_take_a: assert property (HOST_CMD_VALID && HOST_CMD_READY
    |=> !HOST_CMD_READY) else $error("host ready stayed high");
endmodule

bind serial_uplink_mux_router uplink_props u_props (.CLK, .RST, .SCAN_VALID,
  .SCAN_READY, .TLM_VALID, .TLM_READY, .SAMPLER_CMD_VALID, .DEMUX_EN,
  .LINK_VALID, .LINK_READY, .DECK_SCAN_VALID, .REC_VALID, .HOST_CMD_VALID,
  .HOST_CMD_READY, .SAMPLER_RESP_VALID, .SCAN_DATA, .TLM_DATA,
  .SAMPLER_CMD_DATA, .LINK_DATA, .DECK_SCAN_DATA, .SAMPLER_RESP_DATA);

`default_nettype wire

// ### ser_src.sv
`timescale 1ns/1ps
`default_nettype none

module ser_src
#(
  parameter int BIT = 12
)
(
  // serial line out, idle high
  output var logic line
);
  initial line = 1'b1;

  // ------------------------------------------------------------
  // one 8N1 character, LSB first
  // ------------------------------------------------------------
  task automatic send(input logic [7:0] b);
    int i;
    line = 1'b0;
    #(BIT*25);
    for (i = 0; i < 8; i++)
    begin
      line = b[i];
      #(BIT*25);
    end
    line = 1'b1;
    #(BIT*25);
  endtask
endmodule

`default_nettype wire

// ### serial_uplink_mux_router_bench.sv
`timescale 1ns/1ps
`default_nettype none

module serial_uplink_mux_router_bench;
  logic CLK, RST, INST_BAUD_FAST, SCAN_VALID, SCAN_LAST, TLM_READY, DEMUX_EN;
  logic LINK_VALID, LINK_SCAN_END, HOST_CMD_VALID;
  logic [7:0] SCAN_DATA, LINK_DATA, HOST_CMD_DATA;
  wire logic INST_RXD, WET_MODEM_RXD, DECK_MODEM_RXD, INST_TXD, INST_OVERRUN;
  wire logic SCAN_READY, TLM_VALID, SAMPLER_CMD_VALID, LINK_READY, REC_VALID;
  wire logic DECK_SCAN_VALID, UPLINK_TXD, DECK_MODEM_TXD, HOST_CMD_READY;
  wire logic SAMPLER_RESP_VALID;
  wire logic [7:0] TLM_DATA, SAMPLER_CMD_DATA, DECK_SCAN_DATA, REC_DATA;
  wire logic [7:0] SAMPLER_RESP_DATA;
  int num_errors = 0;
  int checks = 0;

  serial_uplink_mux_router #(.MODEM_BIT_CYC(18'h14), .SLOW_BIT_CYC(18'hC))
    DUT (.*);
  ser_src P_INST (.line(INST_RXD));
  ser_src #(.BIT(20)) P_WMOD (.line(WET_MODEM_RXD));
  ser_src #(.BIT(20)) P_DMOD (.line(DECK_MODEM_RXD));

  initial
  begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask

  function automatic logic sel(input int i);
    case (i)
      0: return SAMPLER_CMD_VALID;
      1: return SAMPLER_RESP_VALID;
      2: return TLM_VALID;
      3: return INST_TXD;
      4: return UPLINK_TXD;
      default: return DECK_MODEM_TXD;
    endcase
  endfunction

  task automatic waitv(input int i);
    int n;
    for (n = 0; n < 600 && sel(i) !== 1'b1; n++) @(negedge CLK);
    cmp({7'h0, sel(i)}, 8'h01);
  endtask

  task automatic ser_get(input int i, input int b, input logic [7:0] e);
    int n;
    logic [7:0] d;
    for (n = 0; n < 30000 && sel(i) !== 1'b0; n++) @(negedge CLK);
    repeat (b/2) @(negedge CLK);
    for (n = 0; n < 8; n++)
    begin
      repeat (b) @(negedge CLK);
      d[n] = sel(i);
    end
    repeat (b) @(negedge CLK);
    cmp(d, e);
    cmp({7'h0, sel(i)}, 8'h01);
  endtask

  task automatic link(input logic [7:0] b, input logic e, input logic s);
    @(negedge CLK);
    {LINK_DATA, LINK_VALID, LINK_SCAN_END} = {b, 1'b1, e};
    @(negedge CLK);
    {LINK_VALID, LINK_SCAN_END} = 2'b00;
    cmp({6'h0, DECK_SCAN_VALID, REC_VALID}, {6'h0, s, s & ~DEMUX_EN});
    if (s) cmp(DECK_SCAN_DATA, b);
    if (s && !DEMUX_EN) cmp(REC_DATA, b);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_route;
    fork P_WMOD.send(8'h85); waitv(0); join
    cmp(SAMPLER_CMD_DATA, 8'h85);
    fork P_WMOD.send(8'h41); ser_get(3, 12, 8'h41); join
  endtask

  task automatic t_packet(input logic [7:0] s, input logic [7:0] q[$]);
    repeat (3) @(negedge CLK);
    cmp({7'h0, SCAN_READY}, 8'h01);
    TLM_READY = 1'b0;
    {SCAN_DATA, SCAN_VALID, SCAN_LAST} = {s, 2'b11};
    @(negedge CLK);
    {SCAN_VALID, SCAN_LAST} = 2'b00;
    repeat (3) @(negedge CLK);
    TLM_READY = 1'b1;
    foreach (q[k])
    begin
      waitv(2);
      cmp(TLM_DATA, q[k]);
      @(negedge CLK);
    end
  endtask

  task automatic t_deck;
    link(8'h30, 1'b1, 1'b1);
    DEMUX_EN = 1'b1;
    repeat (4) @(negedge CLK);
    link(8'h31, 1'b1, 1'b1);
    link(8'h01, 1'b0, 1'b0);
    link(8'h5A, 1'b0, 1'b0);
    ser_get(4, 2083, 8'h5A);
    link(8'h32, 1'b1, 1'b1);
    link(8'h00, 1'b0, 1'b0);
    link(8'h33, 1'b0, 1'b1);
  endtask

  task automatic t_modem;
    fork P_DMOD.send(8'h91); waitv(1); join
    cmp(SAMPLER_RESP_DATA, 8'h91);
    @(negedge CLK);
    {HOST_CMD_DATA, HOST_CMD_VALID} = {8'h22, 1'b1};
    @(negedge CLK);
    HOST_CMD_VALID = 1'b0;
    ser_get(5, 20, 8'h22);
  endtask

  task automatic t_fast;
    INST_BAUD_FAST = 1'b1;
    repeat (3) @(negedge CLK);
    fork P_WMOD.send(8'h2E); ser_get(3, 2083, 8'h2E); join
  endtask

  task automatic conclude;
    $display("num_errors=%0d checks=%0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    {RST, INST_BAUD_FAST, SCAN_VALID, SCAN_LAST, TLM_READY} = 5'h10;
    {DEMUX_EN, LINK_VALID, LINK_SCAN_END, HOST_CMD_VALID} = 4'h0;
    {SCAN_DATA, LINK_DATA, HOST_CMD_DATA} = 24'h0;
    repeat (2) @(negedge CLK);
    RST = 1'b0;
    repeat (3) @(negedge CLK);
    cmp({5'h0, INST_TXD, UPLINK_TXD, DECK_MODEM_TXD}, 8'h07);
    t_route();
    P_INST.send(8'h3C);
    P_INST.send(8'hA5);
    t_packet(8'h77, '{8'h77, 8'h02, 8'h3C, 8'hA5});
    t_packet(8'h12, '{8'h12, 8'h00});
    cmp({7'h0, INST_OVERRUN}, 8'h00);
    t_deck();
    t_modem();
    t_fast();
    conclude();
  end

  initial
  begin
    #1500000;
    num_errors++;
    conclude();
  end
endmodule

`default_nettype wire
